// ===== verilog/dcc_core_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "dcc_defs.svh"
module dcc_core_ctrl
    import dcc_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address and data
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // core side
    input  wire logic [2:0]  loop_nest_depth,
    input  wire logic [2:0]  status_word_prio,
    input  wire logic        priority_raise,
    output dcc_ctrl_s        ctrl,
    output logic             early_loop_exit,
    output logic [3:0]       cpu_priority_level
);

    // ----------------------------------------------------------------
    // write channel capture
    // ----------------------------------------------------------------
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [35:0] w_pack;
    logic        wr_go;
    logic        bvalid_r;

    assign wr_go = aw_held && w_held && !bvalid_r;

    dcc_hold_chan #(.W(12)) u_aw (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .in_valid (s_axi_awvalid),
        .in_data  (s_axi_awaddr),
        .take     (wr_go),
        .held     (aw_held),
        .data     (aw_addr)
    );

    dcc_hold_chan #(.W(36)) u_w (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .in_valid (s_axi_wvalid),
        .in_data  ({s_axi_wstrb, s_axi_wdata}),
        .take     (wr_go),
        .held     (w_held),
        .data     (w_pack)
    );

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire        wr_ctrl = wr_go && (aw_addr == `DCC_CTRL_OFS);
    wire        wr_stat = wr_go && (aw_addr == `DCC_STAT_OFS);
    wire        wr_hit  = wr_ctrl || wr_stat;
    wire [31:0] wdata   = w_pack[31:0];
    wire [3:0]  wstrb   = w_pack[35:32];
    wire [15:0] bytemask = {{8{wstrb[1]}}, {8{wstrb[0]}}};

    // ----------------------------------------------------------------
    // control word
    // ----------------------------------------------------------------
    logic [15:0] cw_r;
    logic [15:0] cw_nxt;
    logic        prio_msb_r;
    logic        prio_msb_nxt;
    logic        exit_r;
    logic        exit_nxt;

    // read-only and unimplemented bits are masked off here
    wire [15:0] wmask = bytemask & `DCC_WMASK;
    assign cw_nxt = wr_ctrl ? ((cw_r & ~wmask) | (wdata[15:0] & wmask))
                            : cw_r;

    // set wins over a same-cycle clear; software can never set it
    wire clr_msb = wr_ctrl && wstrb[0] && !wdata[`DCC_PMSB_BIT];
    assign prio_msb_nxt = priority_raise ? 1'b1
                        : (clr_msb ? 1'b0 : prio_msb_r);

    // one-cycle pulse, never stored in the readable word
    assign exit_nxt = wr_ctrl && wstrb[1] && wdata[`DCC_EXIT_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cw_r       <= `DCC_RESET;
            prio_msb_r <= 1'b0;
            exit_r     <= 1'b0;
        end else begin
            cw_r       <= cw_nxt;
            prio_msb_r <= prio_msb_nxt;
            exit_r     <= exit_nxt;
        end
    end

    assign ctrl.var_latency        = cw_r[`DCC_VLAT_BIT];
    assign ctrl.multiply_sign_mode =
        dcc_msign_e'(cw_r[`DCC_MSIGN_HI:`DCC_MSIGN_LO]);
    assign ctrl.acc_a_clamp_en     = cw_r[`DCC_CLPA_BIT];
    assign ctrl.acc_b_clamp_en     = cw_r[`DCC_CLPB_BIT];
    assign ctrl.store_clamp_en     = cw_r[`DCC_CLPST_BIT];
    assign ctrl.clamp_width_select = cw_r[`DCC_CLPW_BIT];
    assign ctrl.frac_mode          = cw_r[`DCC_FRAC_BIT];
    assign ctrl.round_mode         = cw_r[`DCC_ROUND_BIT];
    assign ctrl.int_mode           = cw_r[`DCC_INTM_BIT];
    assign early_loop_exit         = exit_r;
    assign cpu_priority_level      = {prio_msb_r, status_word_prio};

    // read image: loop depth live, exit bit zero, bit 14 zero
    wire [15:0] cw_view;
    assign cw_view = {cw_r[15], 1'b0, cw_r[13:12], 1'b0,
                      loop_nest_depth,
                      cw_r[7:4], prio_msb_r, cw_r[2:0]};

    // ----------------------------------------------------------------
    // write response
    // ----------------------------------------------------------------
    logic [1:0] bresp_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `DCC_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    dcc_rd_e     rd_st_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    wire rd_go   = (rd_st_r == DCC_RD_IDLE) && s_axi_arvalid;
    wire rd_ctrl = s_axi_araddr == `DCC_CTRL_OFS;
    wire rd_stat = s_axi_araddr == `DCC_STAT_OFS;
    wire [31:0] rd_word = rd_ctrl ? {16'h0000, cw_view}
                        : (rd_stat ? {28'h0000000, cpu_priority_level}
                                   : 32'h00000000);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_st_r <= DCC_RD_IDLE;
            rdata_r <= 32'h00000000;
            rresp_r <= `DCC_RESP_OKAY;
        end else begin
            case (rd_st_r)
                DCC_RD_IDLE: begin
                    if (rd_go) begin
                        rd_st_r <= DCC_RD_RESP;
                        rdata_r <= rd_word;
                        rresp_r <= (rd_ctrl || rd_stat) ? `DCC_RESP_OKAY
                                                        : `DCC_RESP_SLVERR;
                    end
                end
                default: begin
                    if (s_axi_rready) begin
                        rd_st_r <= DCC_RD_IDLE;
                    end
                end
            endcase
        end
    end
    assign s_axi_arready = (rd_st_r == DCC_RD_IDLE);
    assign s_axi_rvalid  = (rd_st_r == DCC_RD_RESP);
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    exit_pulse_a: assert property (
        early_loop_exit |=> !early_loop_exit)
        else $error("early exit longer than one cycle");
    exit_cause_a: assert property (
        wr_ctrl && wstrb[1] && wdata[`DCC_EXIT_BIT] |=> early_loop_exit)
        else $error("early exit not raised");
    exit_reads0_a: assert property (
        s_axi_rvalid |-> !s_axi_rdata[`DCC_EXIT_BIT])
        else $error("early exit bit read as one");
    depth_view_a: assert property (
        rd_go && rd_ctrl |=> s_axi_rdata[`DCC_DEPTH_HI:`DCC_DEPTH_LO]
                             == $past(loop_nest_depth))
        else $error("loop depth not reported");
    msb_set_a: assert property (
        priority_raise |=> cpu_priority_level[3])
        else $error("priority msb not set");
    msb_hold_a: assert property (
        !priority_raise && !wr_ctrl |=> $stable(prio_msb_r))
        else $error("priority msb changed without cause");
    level_join_a: assert property (
        cpu_priority_level[2:0] == status_word_prio)
        else $error("priority level not joined");
    ro_ignored_a: assert property (
        wr_ctrl |=> cw_r[14] == 1'b0 && cw_r[11:8] == 4'h0)
        else $error("read-only bits written");
    sat_write_a: assert property (
        wr_ctrl && wstrb[0] |=> ctrl.acc_a_clamp_en
                                == $past(wdata[`DCC_CLPA_BIT]))
        else $error("acc a clamp not written");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    store_clamp_c: cover property (wr_ctrl && !wdata[`DCC_CLPST_BIT]);
    exit_c: cover property (early_loop_exit);
    msb_clear_c: cover property (prio_msb_r ##1 !prio_msb_r);
    bad_addr_c: cover property (s_axi_rvalid && s_axi_rresp != 2'h0);

endmodule // dcc_core_ctrl
`default_nettype wire

// ===== common/dcc_defs.svh
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// register offsets (byte addresses, arbitrary map)
`define DCC_CTRL_OFS      12'h000
`define DCC_STAT_OFS      12'h004

// core control word field positions
`define DCC_VLAT_BIT      15
`define DCC_MSIGN_HI      13
`define DCC_MSIGN_LO      12
`define DCC_EXIT_BIT      11
`define DCC_DEPTH_HI      10
`define DCC_DEPTH_LO      8
`define DCC_CLPA_BIT      7
`define DCC_CLPB_BIT      6
`define DCC_CLPST_BIT     5
`define DCC_CLPW_BIT      4
`define DCC_PMSB_BIT      3
`define DCC_FRAC_BIT      2
`define DCC_ROUND_BIT     1
`define DCC_INTM_BIT      0

// writable bits and reset value
`define DCC_WMASK         16'hb0f7
`define DCC_RESET         16'h0020

// axi responses
`define DCC_RESP_OKAY     2'h0
`define DCC_RESP_SLVERR   2'h2

`endif

// ===== common/dcc_pkg.sv
package dcc_pkg;

    typedef enum logic [1:0] {
        DCC_MUL_SIGNED   = 2'h0,
        DCC_MUL_UNSIGNED = 2'h1,
        DCC_MUL_MIXED    = 2'h2,
        DCC_MUL_RSVD     = 2'h3
    } dcc_msign_e;

    // datapath controls fanned out to the core
    typedef struct packed {
        logic       var_latency;
        dcc_msign_e multiply_sign_mode;
        logic       acc_a_clamp_en;
        logic       acc_b_clamp_en;
        logic       store_clamp_en;
        logic       clamp_width_select;
        logic       frac_mode;
        logic       round_mode;
        logic       int_mode;
    } dcc_ctrl_s;

    typedef enum logic [1:0] {
        DCC_RD_IDLE = 2'h0,
        DCC_RD_RESP = 2'h1
    } dcc_rd_e;

endpackage

// ===== verilog/dcc_hold.sv
`timescale 1ns/1ns
`default_nettype none
// holds one AXI channel payload until taken
module dcc_hold_chan #(
    parameter int W = 32
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    input  wire logic         take,
    output logic              held,
    output logic [W-1:0]      data
);
    logic held_r;
    logic [W-1:0] data_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            held_r <= 1'b0;
            data_r <= '0;
        end else if (take) begin
            held_r <= 1'b0;
        end else if (in_valid && !held_r) begin
            held_r <= 1'b1;
            data_r <= in_data;
        end
    end

    assign held = held_r;
    assign data = data_r;
endmodule // dcc_hold_chan
`default_nettype wire

// ===== verif/test_dcc_core_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module test_dcc_core_ctrl
    import dcc_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        aclk, aresetn;
    logic [11:0] awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic        arvalid, arready, rvalid, rready;
    logic [2:0]  depth, prio;
    logic        raise, exit_p;
    dcc_ctrl_s   ctrl;
    logic [3:0]  level;
    logic [31:0] got;
    int          n_fail, compares, pulses;
    logic [15:0] row_w [7] = '{16'hffff, 16'h0000, 16'h1010, 16'h2040,
                               16'h3080, 16'h8025, 16'h4708};
    logic [2:0]  row_d [7] = '{3'h5, 3'h0, 3'h7, 3'h1, 3'h0, 3'h2, 3'h0};
    logic [15:0] row_e [7] = '{16'hb5f7, 16'h0000, 16'h1710, 16'h2140,
                               16'h3080, 16'h8225, 16'h0000};

    dcc_core_ctrl dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .loop_nest_depth(depth),
        .status_word_prio(prio), .priority_raise(raise), .ctrl(ctrl),
        .early_loop_exit(exit_p), .cpu_priority_level(level)
    );

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // one-cycle pulses are counted, not timed, to stay race free
    always @(posedge aclk) if (exit_p === 1'b1) pulses++;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task finish_test;
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d,
                      input logic [3:0] s);
        bit done;
        done = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= {16'h0, d}; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp; bready <= 1'b0; done = 1;
            end
        end
        if (!done) begin n_fail++; finish_test; end
    endtask

    task automatic rd(input logic [11:0] a);
        bit done;
        done = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                got = rdata; resp = rresp; rready <= 1'b0; done = 1;
            end
        end
        if (!done) begin n_fail++; finish_test; end
    endtask

    function automatic logic [31:0] ctl(input logic [15:0] e);
        return {22'h0, e[15], e[13:12], e[7:4], e[2:0]};
    endfunction

    task automatic reset_dut;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h000);
        chk(got, 32'h0000_0020);
        chk({22'h0, ctrl}, ctl(16'h0020));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_fail = 0; compares = 0; pulses = 0;
        awaddr = '0; awvalid = 0; wdata = '0; wstrb = '0;
        wvalid = 0; bready = 0; araddr = '0; arvalid = 0; rready = 0;
        depth = '0; prio = '0; raise = 0; resp = '0; got = '0;
        reset_dut();
        chk({28'h0, level}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            depth <= row_d[i];
            wr(12'h000, row_w[i], 4'hf);
            rd(12'h000);
            chk(got, {16'h0, row_e[i]});
            chk({22'h0, ctrl}, ctl(row_e[i]));
        end
        chk(pulses, 1);
        wr(12'h000, 16'h0800, 4'hf);
        rd(12'h000);
        chk(got, 32'h0);
        chk(pulses, 2);
        wr(12'h000, 16'hffff, 4'h2);
        rd(12'h000);
        chk(got, 32'h0000_b000);
        // raise the priority msb, then try set and clear by software
        @(posedge aclk);
        prio <= 3'h5; raise <= 1'b1;
        @(posedge aclk);
        raise <= 1'b0;
        rd(12'h000);
        chk(got, 32'h0000_b008);
        chk({28'h0, level}, 32'hd);
        rd(12'h004);
        chk(got, 32'hd);
        wr(12'h000, 16'h0008, 4'hf);
        rd(12'h000);
        chk(got, 32'h0000_0008);
        wr(12'h000, 16'h0000, 4'hf);
        rd(12'h000);
        chk(got, 32'h0);
        chk({28'h0, level}, 32'h5);
        // unmapped place: error response, no effect
        wr(12'h010, 16'hffff, 4'hf);
        chk({30'h0, resp}, 32'h2);
        rd(12'h010);
        chk({30'h0, resp}, 32'h2);
        chk(got, 32'h0);
        rd(12'h000);
        chk(got, 32'h0);
        wr(12'h000, 16'h00d0, 4'hf);
        reset_dut();
        chk({28'h0, level}, 32'h5);
        finish_test;
    end
endmodule // test_dcc_core_ctrl
`default_nettype wire
